// ===== src/acer_unit.v
// Purpose: fatal adapter check detection, reporting and receive stop
// Assumes: bus master events and list checks arrive on i_ref_clk
// Notes: first failure wins; only adapter reset or i_sys_rst clears it
// Notes: the claim pin is resynchronised, so the timeout sees it two cycles late
// Notes: end-of-frame counters and end-of-channel flags are held cleared while dead
//
// The address map and the plain strobed port were decided locally.
`include "acer_regs.vh"
module acer_unit (
  input wire i_ref_clk, // 25 MHz clock
  input wire i_sys_rst, // Sync reset, high
  input wire [2:0] i_addr, // Register word address
  input wire [31:0] i_wdata, // Write data
  input wire i_wr, // Write strobe
  input wire i_rd, // Read strobe
  output reg [31:0] o_rdata, // Read data, cycle after strobe
  input wire i_parity_check_enable, // Parity checking enabled
  input wire i_mst_active, // Master cycle in progress
  input wire i_mst_start, // Master transfer start pulse
  input wire i_target_claim_signal, // Target claim, pin, active high
  input wire i_data_parity_fault, // Data parity error seen
  input wire i_address_parity_fault, // Address parity error seen
  input wire i_target_abort, // Target abort seen
  input wire [7:0] i_chan, // Active channel
  input wire i_list_op, // List not data
  input wire i_rx_op, // Receive not transmit
  input wire i_rd_op, // Read not write
  input wire i_frag_valid, // Fragment count word pulse
  input wire [31:0] i_frag_count, // Fragment count word
  input wire i_list_start, // New list pulse
  input wire i_list_rx, // List is receive
  input wire [15:0] i_frame_size, // Transmit frame size
  input wire i_list_end, // List fully read pulse
  input wire i_rx_eof, // Receive end of frame pulse
  input wire i_tx_eof, // Transmit end of frame pulse
  input wire i_tx_eoc, // Transmit end of channel pulse
  input wire i_rx_fwd_zero, // Zero receive forward pointer pulse
  output reg o_master_abort, // Abort current master cycle
  output reg o_rx_run, // Receive channel running
  output reg o_off_net, // Unrecoverable, off the wire
  output reg [2:0] o_int_type, // Interrupt type
  output reg [7:0] o_int_vec, // Interrupt vector
  output wire o_irq // Interrupt, high level
);

  reg claim_s1_q;
  reg claim_s2_q;
  reg [2:0] claim_cnt_q;
  reg claim_wait_q;
  reg fatal_q;
  reg [31:0] parm_q;
  reg [31:0] rx_list_q;
  reg [9:0] rx_pend_q;
  reg [9:0] tx_pend_q;
  reg rx_eoc_q;
  reg tx_eoc_q;
  reg [2:0] st_q;
  reg [2:0] mask_q;
  reg [15:0] sum_q;
  reg last_ok_q;
  reg list_rx_q;
  reg err_d;
  reg [31:0] parm_d;

  // Register write decode, shared by every writable word
  function acer_hit;
    input wr;
    input [2:0] addr;
    input [2:0] want;
    begin
      acer_hit = wr && (addr == want);
    end
  endfunction

  // Decoded writes and host command fields
  wire [2:0] ack_n = i_wdata[2:0];
  wire cmd_wr = acer_hit(i_wr, i_addr, `ACER_ADDR_HOST_CMD);
  wire parm_wr = acer_hit(i_wr, i_addr, `ACER_ADDR_CHANNEL_PARAMETER_REG);
  wire st_wr = acer_hit(i_wr, i_addr, `ACER_ADDR_STATUS);
  wire mask_wr = acer_hit(i_wr, i_addr, `ACER_ADDR_MASK);
  wire [2:0] st_clr = st_wr ? i_wdata[2:0] : 3'h0;
  wire ack_rx = i_wdata[`ACER_CMD_RXSEL_BIT];
  wire adp_rst = cmd_wr && i_wdata[`ACER_CMD_RST_BIT];

  // Bus fault sources
  wire apar_hit = i_address_parity_fault && i_parity_check_enable;
  wire dpar_hit = i_mst_active && i_data_parity_fault && i_parity_check_enable;
  wire tabt_hit = i_mst_active && i_target_abort;
  // List error sources; frame size only counts for transmit lists
  wire sum_bad = !list_rx_q && (sum_q != i_frame_size);
  wire list_hit = i_list_end && (!last_ok_q || sum_bad);
  // Acknowledge and counter overflow sources
  wire [9:0] ack_pend = ack_rx ? rx_pend_q : tx_pend_q;
  wire ack_hit = cmd_wr && (ack_n != 3'h0) && !i_wdata[`ACER_CMD_RST_BIT]
                 && ({7'h00, ack_n} > ack_pend);
  wire rx_ovf = i_rx_eof && (rx_pend_q == `ACER_CNT_MAX);
  wire tx_ovf = i_tx_eof && (tx_pend_q == `ACER_CNT_MAX);
  // Go while the one-bit end-of-channel count is still full
  wire rxgo_hit = cmd_wr && i_wdata[`ACER_CMD_RXGO_BIT] && rx_eoc_q
                  && !i_wdata[`ACER_CMD_RXEOC_BIT];
  wire txgo_hit = cmd_wr && i_wdata[`ACER_CMD_TXGO_BIT] && tx_eoc_q
                  && !i_wdata[`ACER_CMD_TXEOC_BIT];

  // Build qualifier word for a code
  function [31:0] acer_pack;
    input [7:0] code;
    input chq;
    input ld;
    input rt;
    input rw;
    begin
      acer_pack = {24'h000000, code};
      if (chq) begin
        acer_pack[28:21] = i_chan;
        acer_pack[`ACER_RT_BIT] = rt;
      end
      acer_pack[`ACER_LD_BIT] = ld;
      acer_pack[`ACER_RW_BIT] = rw;
    end
  endfunction

  // Claim pin synchroniser
  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      claim_s1_q <= 1'b0;
      claim_s2_q <= 1'b0;
    end else begin
      claim_s1_q <= i_target_claim_signal;
      claim_s2_q <= claim_s1_q;
    end
  end

  // Claim timeout counter
  always @(posedge i_ref_clk) begin
    if (i_sys_rst || adp_rst) begin
      claim_cnt_q <= 3'h0;
      claim_wait_q <= 1'b0;
      o_master_abort <= 1'b0;
    end else begin
      o_master_abort <= 1'b0;
      if (i_mst_start) begin
        claim_wait_q <= 1'b1;
        claim_cnt_q <= 3'h0;
      end else if (claim_wait_q && claim_s2_q) begin
        claim_wait_q <= 1'b0;
      end else if (claim_wait_q) begin
        if (claim_cnt_q == `ACER_CLAIM_CYCLES - 3'h1) begin
          claim_wait_q <= 1'b0;
          o_master_abort <= 1'b1;
        end else begin
          claim_cnt_q <= claim_cnt_q + 3'h1;
        end
      end
    end
  end

  // Failure detection in priority order
  always @* begin
    err_d = 1'b1;
    parm_d = 32'h00000000;
    if (apar_hit) begin
      parm_d = {24'h000000, `ACER_CODE_APAR};
    end else if (dpar_hit) begin
      parm_d = acer_pack(`ACER_CODE_DPAR, 1'b1, i_list_op, i_rx_op, i_rd_op);
    end else if (o_master_abort) begin
      parm_d = acer_pack(`ACER_CODE_MABT, 1'b1, i_list_op, i_rx_op, i_rd_op);
    end else if (tabt_hit) begin
      parm_d = acer_pack(`ACER_CODE_TABT, 1'b1, i_list_op, i_rx_op, i_rd_op);
    end else if (list_hit) begin
      parm_d = acer_pack(`ACER_CODE_LIST, 1'b1, 1'b0, list_rx_q, 1'b0);
    end else if (ack_hit) begin
      parm_d = acer_pack(`ACER_CODE_ACK, 1'b1, 1'b0, ack_rx, 1'b0);
    end else if (rx_ovf || tx_ovf) begin
      parm_d = acer_pack(`ACER_CODE_IOV, 1'b1, 1'b0, rx_ovf, 1'b0);
    end else if (rxgo_hit) begin
      parm_d = acer_pack(`ACER_CODE_IOV, 1'b1, 1'b1, 1'b1, 1'b0);
    end else if (txgo_hit) begin
      parm_d = acer_pack(`ACER_CODE_IOV, 1'b1, 1'b1, 1'b0, 1'b0);
    end else begin
      err_d = 1'b0;
    end
  end

  // List fragment sum and last flag tracking
  always @(posedge i_ref_clk) begin
    if (i_sys_rst || i_list_start) begin
      sum_q <= 16'h0000;
      last_ok_q <= 1'b1;
      list_rx_q <= i_sys_rst ? 1'b0 : i_list_rx;
    end else if (i_frag_valid && i_frag_count[15:0] != 16'h0000) begin
      sum_q <= sum_q + i_frag_count[15:0];
      last_ok_q <= i_frag_count[`ACER_LAST_FRAG_BIT];
    end
  end

  // Fatal latch and parameter register
  always @(posedge i_ref_clk) begin
    if (i_sys_rst || adp_rst) begin
      fatal_q <= 1'b0;
      parm_q <= 32'h00000000;
      rx_list_q <= 32'h00000000;
    end else if (!fatal_q && err_d) begin
      fatal_q <= 1'b1;
      parm_q <= parm_d;
    end else if (!fatal_q && parm_wr) begin
      rx_list_q <= i_wdata;
    end
  end

  // Pending end-of-frame and end-of-channel counters
  always @(posedge i_ref_clk) begin
    if (i_sys_rst || adp_rst || fatal_q) begin
      rx_pend_q <= 10'h000;
      tx_pend_q <= 10'h000;
      rx_eoc_q <= 1'b0;
      tx_eoc_q <= 1'b0;
      o_rx_run <= 1'b0;
    end else if (!err_d) begin
      rx_pend_q <= rx_pend_q + {9'h000, i_rx_eof}
                   - ((cmd_wr && ack_rx) ? {7'h00, ack_n} : 10'h000);
      tx_pend_q <= tx_pend_q + {9'h000, i_tx_eof}
                   - ((cmd_wr && !ack_rx) ? {7'h00, ack_n} : 10'h000);
      if (i_rx_fwd_zero) begin
        rx_eoc_q <= 1'b1;
        o_rx_run <= 1'b0;
      end else begin
        if (cmd_wr && i_wdata[`ACER_CMD_RXEOC_BIT])
          rx_eoc_q <= 1'b0;
        if (cmd_wr && i_wdata[`ACER_CMD_RXGO_BIT])
          o_rx_run <= 1'b1;
      end
      if (i_tx_eoc)
        tx_eoc_q <= 1'b1;
      else if (cmd_wr && i_wdata[`ACER_CMD_TXEOC_BIT])
        tx_eoc_q <= 1'b0;
    end
  end

  // Sticky status bits, set wins over a write-one clear
  wire [2:0] st_set = {i_tx_eoc & ~fatal_q, i_rx_fwd_zero & ~fatal_q, fatal_q | err_d};
  wire [2:0] st_d;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_st
      assign st_d[gi] = st_set[gi] | (st_q[gi] & ~st_clr[gi]);
    end
  endgenerate

  // Status and mask registers
  always @(posedge i_ref_clk) begin
    if (i_sys_rst || adp_rst) begin
      st_q <= 3'h0;
      mask_q <= `ACER_RST_MASK;
    end else begin
      st_q <= st_d;
      if (mask_wr)
        mask_q <= i_wdata[2:0];
    end
  end

  // Level interrupt from unmasked sticky bits
  assign o_irq = |(st_q & mask_q);

  // Interrupt type and vector, fatal first
  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_int_type <= 3'h0;
      o_int_vec <= 8'h00;
      o_off_net <= 1'b0;
    end else begin
      o_off_net <= fatal_q;
      if (fatal_q) begin
        o_int_type <= `ACER_TYPE_STATUS;
        o_int_vec <= parm_q[7:0];
      end else if (rx_eoc_q) begin
        o_int_type <= `ACER_TYPE_RX_EOC;
        o_int_vec <= 8'h00;
      end else begin
        o_int_type <= 3'h0;
        o_int_vec <= 8'h00;
      end
    end
  end

  // Register read port
  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_rdata <= 32'h00000000;
    end else if (i_rd) begin
      case (i_addr)
        `ACER_ADDR_CHANNEL_PARAMETER_REG: o_rdata <= fatal_q ? parm_q : rx_list_q;
        `ACER_ADDR_STATUS: o_rdata <= {29'h0000000, st_q};
        `ACER_ADDR_MASK: o_rdata <= {29'h0000000, mask_q};
        `ACER_ADDR_CTRL: o_rdata <= {29'h0000000, o_off_net, rx_eoc_q, o_rx_run};
        `ACER_ADDR_PEND: o_rdata <= {6'h0, rx_pend_q, 6'h0, tx_pend_q};
        // Host command word is write only
        default: o_rdata <= 32'h00000000;
      endcase
    end else begin
      o_rdata <= 32'h00000000;
    end
  end
endmodule

// ===== src/acer_regs.vh
// Purpose: constants of the adapter check reporting unit
// Assumes: 25 MHz clock, plain register port with 3-bit word address
// Notes: failure codes and field positions fixed by the hardware
`ifndef ACER_REGS_VH
`define ACER_REGS_VH
`define ACER_CODE_NONE 8'h00
`define ACER_CODE_DPAR 8'h01
`define ACER_CODE_APAR 8'h02
`define ACER_CODE_MABT 8'h03
`define ACER_CODE_TABT 8'h04
`define ACER_CODE_LIST 8'h05
`define ACER_CODE_ACK 8'h06
`define ACER_CODE_IOV 8'h07
`define ACER_CHAN_LSB 21
`define ACER_LD_BIT 20
`define ACER_RT_BIT 19
`define ACER_RW_BIT 18
`define ACER_LAST_FRAG_BIT 31
`define ACER_CLAIM_CYCLES 3'h6
`define ACER_CNT_MAX 10'h3FF
`define ACER_TYPE_STATUS 3'h6
`define ACER_TYPE_RX_EOC 3'h7
`define ACER_ADDR_CHANNEL_PARAMETER_REG 3'h0
`define ACER_ADDR_HOST_CMD 3'h1
`define ACER_ADDR_STATUS 3'h2
`define ACER_ADDR_MASK 3'h3
`define ACER_ADDR_CTRL 3'h4
`define ACER_ADDR_PEND 3'h5
`define ACER_CMD_RST_BIT 31
`define ACER_CMD_TXGO_BIT 30
`define ACER_CMD_RXGO_BIT 29
`define ACER_CMD_TXEOC_BIT 28
`define ACER_CMD_RXEOC_BIT 27
`define ACER_CMD_RXSEL_BIT 26
`define ACER_ST_FATAL 0
`define ACER_ST_RXEOC 1
`define ACER_ST_TXEOC 2
`define ACER_RST_MASK 3'h0
`endif

// ===== testbench/acer_pci_tgt.sv
// Purpose: PCI target model answering master cycles
// Assumes: claim active high, synced inside the unit
// Notes: delay 0 means that no target claims the cycle
module acer_pci_tgt (
  input logic i_clk, // Clock
  input logic i_start, // Transfer start
  input logic i_active, // Master cycle running
  input logic [3:0] i_delay, // Claim delay, 0 never
  output logic o_claim // Target claim
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q = 4'hF;
  // Cycles since the transfer started, parked at 15 when idle
  always @(posedge i_clk) begin
    if (i_start)
      cnt_q <= 4'h0;
    else if (cnt_q != 4'hF)
      cnt_q <= cnt_q + 4'h1;
  end
  // Claim only inside a cycle; idle low once released
  assign o_claim = i_active && i_delay != 4'h0 && cnt_q >= i_delay && cnt_q != 4'hF;
endmodule

// ===== testbench/acer_unit_sva.sv
// Purpose: port checks of the adapter check unit
// Assumes: one clock, synchronous reset
// Notes: at most one failure per reset episode
module acer_unit_sva (
  input logic i_ref_clk, // Clock
  input logic i_sys_rst, // Reset
  input logic [2:0] i_addr, // Address
  input logic [31:0] i_wdata, // Write data
  input logic i_wr, // Write
  input logic i_parity_check_enable, // Parity on
  input logic i_mst_active, // Master busy
  input logic i_mst_start, // Start
  input logic i_target_claim_signal, // Claim
  input logic i_data_parity_fault, // Data parity
  input logic i_address_parity_fault, // Addr parity
  input logic i_target_abort, // Target abort
  input logic i_rx_fwd_zero, // Zero pointer
  input logic o_master_abort, // Abort
  input logic o_rx_run, // Rx running
  input logic o_off_net, // Dead
  input logic [2:0] o_int_type, // Type
  input logic [7:0] o_int_vec // Vector
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  wire idle = !o_off_net && o_int_vec == 8'h00;
  wire ad_rst = i_wr && i_addr == 3'h1 && i_wdata[31];
  // Code shown, then dead with status type
  sequence s_fail(logic [7:0] c);
    ##[1:3] (o_int_vec == c) ##[0:2] (o_off_net && o_int_type == 3'h6);
  endsequence
  sequence s_noclaim;
    idle && i_mst_start ##1 (i_mst_active && !i_target_claim_signal)[*4];
  endsequence
  property p_dpar;
    idle && i_parity_check_enable && i_mst_active && i_data_parity_fault
      && !i_address_parity_fault |-> s_fail(8'h01);
  endproperty
  a_dpar: assert property (p_dpar) else $error("data parity code");
  property p_apar;
    idle && i_parity_check_enable && i_address_parity_fault |-> s_fail(8'h02);
  endproperty
  a_apar: assert property (p_apar) else $error("address parity code");
  property p_mabt;
    s_noclaim |-> ##[1:6] o_master_abort ##0 s_fail(8'h03);
  endproperty
  a_mabt: assert property (p_mabt) else $error("master abort");
  property p_tabt;
    idle && i_mst_active && i_target_abort && !o_master_abort
      && !(i_data_parity_fault && i_parity_check_enable) && !i_address_parity_fault
      |-> s_fail(8'h04);
  endproperty
  a_tabt: assert property (p_tabt) else $error("target abort code");
  property p_hold;
    o_off_net && !ad_rst && !$past(ad_rst) |=> $stable(o_int_vec) && o_off_net;
  endproperty
  a_hold: assert property (p_hold) else $error("failure not held");
  property p_rst;
    o_off_net && ad_rst |-> ##[1:2] (!o_off_net && o_int_vec == 8'h00);
  endproperty
  a_rst: assert property (p_rst) else $error("adapter reset");
  property p_dead;
    o_int_type == 3'h6 && o_int_vec != 8'h00 |-> ##[0:1] o_off_net;
  endproperty
  a_dead: assert property (p_dead) else $error("not off net");
  property p_rxeoc;
    !o_off_net && i_rx_fwd_zero |-> ##[1:2] (!o_rx_run && o_int_type == 3'h7);
  endproperty
  a_rxeoc: assert property (p_rxeoc) else $error("rx stop");
endmodule
bind acer_unit acer_unit_sva u_sva (.i_ref_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr,
  .i_parity_check_enable, .i_mst_active, .i_mst_start, .i_target_claim_signal,
  .i_data_parity_fault, .i_address_parity_fault, .i_target_abort, .i_rx_fwd_zero,
  .o_master_abort, .o_rx_run, .o_off_net, .o_int_type, .o_int_vec);

// ===== testbench/test_adapter_check_error_reporting.sv
// Purpose: register level tests of the adapter check unit
// Assumes: 25 MHz clock, target model on the claim pin
// Notes: one failure per reset episode
module test_adapter_check_error_reporting;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, wr = 0, rd = 0, pce = 0, act = 0, lo = 0, ro = 0, rw = 0, lr = 0;
  logic claim, mab, run, off, irq;
  logic [10:0] pl = 0;
  logic [2:0] adr = 0, ity;
  logic [7:0] ch = 0, vec;
  logic [15:0] fsz = 0;
  logic [31:0] wd = 0, fc = 0, rdat;
  logic [3:0] dly = 0;
  int miscompares = 0, check_count = 0;
  always #20 clk = ~clk;
  acer_pci_tgt tgt (.i_clk(clk), .i_start(pl[10]), .i_active(act), .i_delay(dly),
    .o_claim(claim));
  acer_unit dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_addr(adr), .i_wdata(wd), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdat), .i_parity_check_enable(pce), .i_mst_active(act),
    .i_mst_start(pl[10]), .i_target_claim_signal(claim), .i_data_parity_fault(pl[0]),
    .i_address_parity_fault(pl[1]), .i_target_abort(pl[2]), .i_chan(ch), .i_list_op(lo),
    .i_rx_op(ro), .i_rd_op(rw), .i_frag_valid(pl[3]), .i_frag_count(fc),
    .i_list_start(pl[4]), .i_list_rx(lr), .i_frame_size(fsz), .i_list_end(pl[5]),
    .i_rx_eof(pl[6]), .i_tx_eof(pl[7]), .i_tx_eoc(pl[8]), .i_rx_fwd_zero(pl[9]),
    .o_master_abort(mab), .o_rx_run(run), .o_off_net(off), .o_int_type(ity),
    .o_int_vec(vec), .o_irq(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [31:0] d);
    adr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [31:0] e);
    adr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdat, e);
    @(posedge clk);
  endtask
  task automatic pulse(input int b, input int n = 1);
    repeat (n) begin
      pl[b] <= 1'b1;
      @(posedge clk);
      pl[b] <= 1'b0;
      @(posedge clk);
    end
  endtask
  task automatic frag(input logic [31:0] w);
    fc <= w;
    pulse(3);
  endtask
  // Packed port view: off, irq, run, type, vector
  task automatic ports(input logic [31:0] e);
    repeat (4) @(posedge clk);
    #1 chk({18'h0, off, irq, run, ity, vec}, e);
    @(posedge clk);
  endtask
  task automatic reset_dut;
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wr_reg(3'h3, 32'h7);
  endtask
  function automatic logic [31:0] cw(input logic [7:0] c, input logic [2:0] q);
    return {3'h0, ch, q, 10'h0, c};
  endfunction
  task automatic finish_test;
    if (miscompares == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    finish_test;
  end
  initial begin
    reset_dut;
    pce <= 1'b1;
    act <= 1'b1;
    ch <= 8'hA5;
    {lo, ro, rw} <= 3'b101;
    pulse(0);
    ports(32'h3601);
    rd_chk(3'h0, cw(8'h01, 3'b101));
    pulse(2);
    rd_chk(3'h0, cw(8'h01, 3'b101));
    wr_reg(3'h1, 32'h8000_0000);
    ports(32'h0);
    rd_chk(3'h7, 32'h0);
    reset_dut;
    pce <= 1'b0;
    pulse(1);
    ports(32'h0);
    pce <= 1'b1;
    pulse(1);
    ports(32'h3602);
    rd_chk(3'h0, 32'h2);
    reset_dut;
    ch <= 8'h3C;
    {lo, ro, rw} <= 3'b010;
    pulse(2);
    ports(32'h3604);
    rd_chk(3'h0, cw(8'h04, 3'b010));
    reset_dut;
    dly <= 4'h2;
    pulse(10);
    repeat (8) @(posedge clk);
    ports(32'h0);
    dly <= 4'h0;
    repeat (3) @(posedge clk);
    pulse(10);
    repeat (5) @(posedge clk);
    #1 chk({31'h0, mab}, 32'h1);
    repeat (3) @(posedge clk);
    ports(32'h3603);
    rd_chk(3'h0, cw(8'h03, 3'b010));
    reset_dut;
    {lo, ro, rw} <= 3'b000;
    fsz <= 16'd90;
    pulse(4);
    frag(32'd60);
    frag(32'h8000_001E);
    pulse(5);
    ports(32'h0);
    fsz <= 16'd91;
    pulse(4);
    frag(32'd60);
    frag(32'h8000_001E);
    pulse(5);
    ports(32'h3605);
    rd_chk(3'h0, cw(8'h05, 3'b000));
    reset_dut;
    {lr, ro} <= 2'b11;
    pulse(4);
    frag(32'd40);
    frag(32'd0);
    pulse(5);
    ports(32'h3605);
    rd_chk(3'h0, cw(8'h05, 3'b010));
    reset_dut;
    ch <= 8'h00;
    pulse(6, 2);
    wr_reg(3'h1, 32'h0400_0002);
    rd_chk(3'h5, 32'h0);
    wr_reg(3'h1, 32'h0400_0001);
    ports(32'h3606);
    rd_chk(3'h0, cw(8'h06, 3'b010));
    reset_dut;
    pulse(7, 1023);
    rd_chk(3'h5, 32'h3FF);
    wr_reg(3'h1, 32'h7);
    rd_chk(3'h5, 32'h3F8);
    pulse(7, 7);
    ports(32'h0);
    pulse(7);
    ports(32'h3607);
    rd_chk(3'h0, cw(8'h07, 3'b000));
    reset_dut;
    wr_reg(3'h1, 32'h2000_0000);
    rd_chk(3'h4, 32'h1);
    pulse(9);
    ports(32'h1700);
    rd_chk(3'h2, 32'h2);
    wr_reg(3'h3, 32'h5);
    #1 chk({31'h0, irq}, 32'h0);
    @(posedge clk);
    wr_reg(3'h0, 32'h0000_1000);
    rd_chk(3'h0, 32'h0000_1000);
    wr_reg(3'h1, 32'h2800_0000);
    rd_chk(3'h4, 32'h1);
    pulse(9);
    wr_reg(3'h1, 32'h2000_0000);
    ports(32'h3607);
    rd_chk(3'h0, cw(8'h07, 3'b110));
    finish_test;
  end
endmodule
